// ---- design/amd_pkg.sv ----
// shared constants, register map and carrier types for the alarm/divider bank
package amd_pkg;
  // widths and counts
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_ALARM = 5;
  localparam int unsigned NUM_OUT = 3;
  localparam int unsigned LS_W = 20;
  localparam int unsigned HS_W = 3;
  localparam int unsigned HS_CNT_W = 4;
  localparam int unsigned UP_W = 4;
  localparam int unsigned SYNC_W = NUM_ALARM + 1;
  localparam int unsigned SYNC_INC_BIT = NUM_ALARM;

  typedef logic [DATA_W-1:0] amd_byte_type;

  // register offsets
  localparam amd_byte_type OFF_MASK = 8'h18;
  localparam amd_byte_type OFF_OUT1_UP = 8'h19;
  localparam amd_byte_type OFF_OUT1_MID = 8'h1A;
  localparam amd_byte_type OFF_OUT1_LO = 8'h1B;
  localparam amd_byte_type OFF_OUT2_UP = 8'h1C;
  localparam amd_byte_type OFF_OUT2_MID = 8'h1D;
  localparam amd_byte_type OFF_OUT2_LO = 8'h1E;
  localparam amd_byte_type OFF_OUT3_UP = 8'h1F;
  localparam amd_byte_type OFF_OUT3_MID = 8'h20;
  localparam amd_byte_type OFF_OUT3_LO = 8'h21;

  // reset values
  localparam amd_byte_type RST_MASK = 8'h3F;
  localparam amd_byte_type RST_OUT1_UP = 8'h20;
  localparam amd_byte_type RST_OUT1_MID = 8'h00;
  localparam amd_byte_type RST_OUT1_LO = 8'h31;
  localparam amd_byte_type RST_OUT2_UP = 8'h00;
  localparam amd_byte_type RST_OUT2_MID = 8'h00;
  localparam amd_byte_type RST_OUT2_LO = 8'h31;
  localparam amd_byte_type RST_OUT3_UP = 8'h00;
  localparam amd_byte_type RST_OUT3_MID = 8'h00;
  localparam amd_byte_type RST_OUT3_LO = 8'h31;
  localparam logic IRQ_PIN_RST = 1'h0;

  // field positions
  localparam int unsigned MASK_LOCK_BIT = 0;
  localparam int unsigned MASK_FOS_LSB = 1;
  localparam int unsigned MASK_W = 5;
  localparam int unsigned HS_LSB = 5;
  localparam int unsigned LS_MID_LSB = 8;
  localparam int unsigned LS_UP_LSB = 16;

  // divider arithmetic
  localparam logic [HS_W-1:0] HS_MIN_CODE = 3'h0;
  localparam logic [HS_CNT_W-1:0] HS_LAST_OFS = 4'h3;
  localparam logic [HS_CNT_W-1:0] HS_ONE = 4'h1;
  localparam logic [LS_W-1:0] LS_ONE = 20'h00001;

  // register port request and answer
  typedef struct packed {
    logic wr;
    logic rd;
    amd_byte_type addr;
    amd_byte_type wdata;
  } amd_req_type;

  typedef struct packed {
    logic valid;
    amd_byte_type data;
  } amd_rsp_type;

  // divider settings handed to the divider chain
  typedef struct packed {
    logic [HS_W-1:0] hs_code;
    logic [NUM_OUT-1:0][LS_W-1:0] ls_code;
  } amd_div_cfg_type;
endpackage : amd_pkg

// ---- design/amd_sync.sv ----
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module amd_sync (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [amd_pkg::SYNC_W-1:0] async_i,
  output logic [amd_pkg::SYNC_W-1:0] sync_o
);
  import amd_pkg::*;

  // s1 is read by s2 only, never by the filter
  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] q;
  } amd_sync_state_type;

  amd_sync_state_type state_ff;
  amd_sync_state_type nxt_state;
  logic [SYNC_W-1:0] agree; // stages two and three match

  // shift chain; a bit only moves once two samples agree
  always_comb begin
    nxt_state = state_ff;
    agree = state_ff.s2 ~^ state_ff.s3;
    nxt_state.s1 = async_i;
    nxt_state.s2 = state_ff.s1;
    nxt_state.s3 = state_ff.s2;
    nxt_state.q = (agree & state_ff.s3) | (~agree & state_ff.q);
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign sync_o = state_ff.q;
endmodule : amd_sync

// ---- design/amd_divchain.sv ----
// shared fast divider feeding three slow output dividers, with skew step
`timescale 1ns/10ps
module amd_divchain (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire amd_pkg::amd_div_cfg_type cfg_i,
  input wire logic inc_req_i,
  output logic hs_tick_o,
  output logic [amd_pkg::NUM_OUT-1:0] tick_o,
  output logic skew_ignored_o
);
  import amd_pkg::*;

  typedef struct packed {
    logic [HS_CNT_W-1:0] hs_cnt; // fast divider phase
    logic skew_pend; // one coarse step waiting
    logic hs_tick; // fast divider output
    logic [NUM_OUT-1:0] tick; // slow divider outputs
    logic [NUM_OUT-1:0][LS_W-1:0] ls_cnt; // slow divider phases
    logic skew_ignored; // step refused
  } amd_div_state_type;

  amd_div_state_type state_ff;
  amd_div_state_type nxt_state;
  logic [HS_CNT_W-1:0] hs_last; // terminal count of fast divider
  logic stall; // hold one cycle for the skew step
  logic hs_term; // fast divider wraps this cycle

  // divider chain; slow counters advance on fast ticks only
  always_comb begin
    nxt_state = state_ff;
    hs_last = {1'h0, cfg_i.hs_code} + HS_LAST_OFS;
    stall = state_ff.skew_pend && (state_ff.hs_cnt == hs_last);
    hs_term = !stall && (state_ff.hs_cnt >= hs_last);
    nxt_state.hs_tick = 1'h0;
    nxt_state.tick = '0;
    nxt_state.skew_ignored = 1'h0;
    // the stretched cycle consumes the pending step
    if (stall) begin
      nxt_state.skew_pend = 1'h0;
    end else if (hs_term) begin
      nxt_state.hs_cnt = '0;
      nxt_state.hs_tick = 1'h1;
    end else begin
      nxt_state.hs_cnt = state_ff.hs_cnt + HS_ONE;
    end
    // coarse step needs a fast ratio above the minimum
    if (cfg_i.hs_code == HS_MIN_CODE) begin
      nxt_state.skew_pend = 1'h0;
      nxt_state.skew_ignored = inc_req_i;
    end else if (inc_req_i) begin
      nxt_state.skew_pend = 1'h1;
    end
    // ratio is code plus one; code zero passes every fast tick
    for (int i = 0; i < NUM_OUT; i++) begin
      if (hs_term) begin
        if (state_ff.ls_cnt[i] >= cfg_i.ls_code[i]) begin
          nxt_state.ls_cnt[i] = '0;
          nxt_state.tick[i] = 1'h1;
        end else begin
          nxt_state.ls_cnt[i] = state_ff.ls_cnt[i] + LS_ONE;
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign hs_tick_o = state_ff.hs_tick;
  assign tick_o = state_ff.tick;
  assign skew_ignored_o = state_ff.skew_ignored;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_HS_MIN_GAP: assert property (state_ff.hs_tick |=> (!state_ff.hs_tick) [*3])
    else $error("fast divider ticked below ratio four");
  AST_HS_RATIO_FOUR: assert property (
    (state_ff.hs_tick && cfg_i.hs_code == HS_MIN_CODE)
    ##1 (cfg_i.hs_code == HS_MIN_CODE) [*3] |=> state_ff.hs_tick)
    else $error("fast divider missed ratio four");
  AST_SKEW_IGNORED: assert property (
    (inc_req_i && cfg_i.hs_code == HS_MIN_CODE)
    |=> (state_ff.skew_ignored && !state_ff.skew_pend))
    else $error("skew step taken at minimum fast ratio");
  AST_LS_ON_HS: assert property ((|state_ff.tick) |-> state_ff.hs_tick)
    else $error("slow divider ticked without fast tick");

  COV_SKEW_IGNORED: cover property (state_ff.skew_ignored);
  COV_SKEW_STALL: cover property (stall);
  COV_OUT1_TICK: cover property (state_ff.tick[0]);
endmodule : amd_divchain

// ---- design/amd_regs.sv ----
// alarm mask and output divider register bank with interrupt pin
`timescale 1ns/10ps

// How it works
// - clear input mask bit lets offset alarm interrupt
// - bit zero masks the lock-loss flag
// - mask writes leave latched flags untouched
// - fast divider ratio is code plus four
// - minimum fast ratio refuses coarse skew steps
// - output one divider split nibble, byte, byte
// - output two divider split the same way
// - output three divider split the same way
// - slow divider ratio is code plus one
// - polarity input chooses interrupt pin level
module amd_regs (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire amd_pkg::amd_req_type req_i,
  output amd_pkg::amd_rsp_type rsp_o,
  input wire logic [amd_pkg::NUM_ALARM-1:0] alarm_raw_i,
  input wire logic [amd_pkg::NUM_ALARM-1:0] flag_clr_i,
  input wire logic irq_pin_en_i,
  input wire logic irq_output_polarity_i,
  input wire logic skew_inc_i,
  output logic irq_o,
  output logic [amd_pkg::NUM_ALARM-1:0] flags_o,
  output logic clock_output_one_o,
  output logic clock_output_two_o,
  output logic clock_output_three_o,
  output logic skew_ignored_o
);
  import amd_pkg::*;

  // whole bank state; flags share bit order with the mask
  typedef struct packed {
    logic [MASK_W-1:0] mask; // lock loss at bit zero
    amd_div_cfg_type cfg; // divider settings
    logic [NUM_ALARM-1:0] flags; // latched alarms
    logic irq_act; // interrupt condition, polarity free
    logic irq; // pin level after polarity
    logic inc_seen; // last synced skew pin level
    amd_rsp_type rsp; // read answer
  } amd_top_state_type;

  amd_top_state_type state_ff;
  amd_top_state_type nxt_state;
  logic [SYNC_W-1:0] sync_q; // filtered pin levels
  logic [NUM_ALARM-1:0] alarm_q; // filtered alarms
  logic inc_req; // skew pin rising edge
  logic irq_pend; // any unmasked latched flag
  amd_byte_type rdata; // read mux result
  logic [NUM_OUT-1:0] out_tick; // divider outputs

  // alarm and skew pins come from outside the clock domain
  amd_sync u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i({skew_inc_i, alarm_raw_i}),
    .sync_o(sync_q)
  );

  assign alarm_q = sync_q[NUM_ALARM-1:0];
  assign inc_req = sync_q[SYNC_INC_BIT] && !state_ff.inc_seen;

  // divider chain runs from the stored settings
  amd_divchain u_div (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .cfg_i(state_ff.cfg),
    .inc_req_i(inc_req),
    .hs_tick_o(), // fast tick not needed at this level
    .tick_o(out_tick),
    .skew_ignored_o(skew_ignored_o)
  );

  // register writes, flag latching, interrupt and read mux
  always_comb begin
    nxt_state = state_ff;
    rdata = '0;
    nxt_state.inc_seen = sync_q[SYNC_INC_BIT];
    // writes; codes are stored as given, legality is the host's job
    if (req_i.wr) begin
      case (req_i.addr)
        OFF_MASK: begin
          nxt_state.mask = req_i.wdata[MASK_W-1:0];
        end
        OFF_OUT1_UP: begin
          nxt_state.cfg.hs_code = req_i.wdata[HS_LSB+:HS_W];
          nxt_state.cfg.ls_code[0][LS_UP_LSB+:UP_W] =
            req_i.wdata[UP_W-1:0];
        end
        OFF_OUT1_MID: begin
          nxt_state.cfg.ls_code[0][LS_MID_LSB+:DATA_W] =
            req_i.wdata;
        end
        OFF_OUT1_LO: begin
          nxt_state.cfg.ls_code[0][DATA_W-1:0] = req_i.wdata;
        end
        OFF_OUT2_UP: begin
          nxt_state.cfg.ls_code[1][LS_UP_LSB+:UP_W] =
            req_i.wdata[UP_W-1:0];
        end
        OFF_OUT2_MID: begin
          nxt_state.cfg.ls_code[1][LS_MID_LSB+:DATA_W] =
            req_i.wdata;
        end
        OFF_OUT2_LO: begin
          nxt_state.cfg.ls_code[1][DATA_W-1:0] = req_i.wdata;
        end
        OFF_OUT3_UP: begin
          nxt_state.cfg.ls_code[2][LS_UP_LSB+:UP_W] =
            req_i.wdata[UP_W-1:0];
        end
        OFF_OUT3_MID: begin
          nxt_state.cfg.ls_code[2][LS_MID_LSB+:DATA_W] =
            req_i.wdata;
        end
        OFF_OUT3_LO: begin
          nxt_state.cfg.ls_code[2][DATA_W-1:0] = req_i.wdata;
        end
        default: begin
          // unmapped writes are dropped
        end
      endcase
    end
    // set wins over clear so no alarm edge is lost; mask never touches
    nxt_state.flags = (state_ff.flags & ~flag_clr_i) | alarm_q;
    // masking gates only the interrupt, never the stored flag
    irq_pend = |(state_ff.flags & ~state_ff.mask);
    nxt_state.irq_act = irq_pin_en_i && irq_pend;
    // disabled pin sits at its inactive level
    nxt_state.irq = irq_output_polarity_i ? nxt_state.irq_act
                                          : !nxt_state.irq_act;
    // reads; reserved bits and unmapped offsets read as zero
    case (req_i.addr)
      OFF_MASK: begin
        rdata = amd_byte_type'(state_ff.mask);
      end
      OFF_OUT1_UP: begin
        rdata = {state_ff.cfg.hs_code, 1'h0,
                 state_ff.cfg.ls_code[0][LS_UP_LSB+:UP_W]};
      end
      OFF_OUT1_MID: begin
        rdata = state_ff.cfg.ls_code[0][LS_MID_LSB+:DATA_W];
      end
      OFF_OUT1_LO: begin
        rdata = state_ff.cfg.ls_code[0][DATA_W-1:0];
      end
      OFF_OUT2_UP: begin
        rdata = amd_byte_type'(state_ff.cfg.ls_code[1][LS_UP_LSB+:UP_W]);
      end
      OFF_OUT2_MID: begin
        rdata = state_ff.cfg.ls_code[1][LS_MID_LSB+:DATA_W];
      end
      OFF_OUT2_LO: begin
        rdata = state_ff.cfg.ls_code[1][DATA_W-1:0];
      end
      OFF_OUT3_UP: begin
        rdata = amd_byte_type'(state_ff.cfg.ls_code[2][LS_UP_LSB+:UP_W]);
      end
      OFF_OUT3_MID: begin
        rdata = state_ff.cfg.ls_code[2][LS_MID_LSB+:DATA_W];
      end
      OFF_OUT3_LO: begin
        rdata = state_ff.cfg.ls_code[2][DATA_W-1:0];
      end
      default: begin
        rdata = '0;
      end
    endcase
    // answer one cycle after the strobe; old data if read and write meet
    nxt_state.rsp.valid = req_i.rd;
    nxt_state.rsp.data = req_i.rd ? rdata : '0;
  end

  // state register with documented reset values
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_ff <= '0;
      state_ff.mask <= RST_MASK[MASK_W-1:0];
      state_ff.cfg.hs_code <= RST_OUT1_UP[HS_LSB+:HS_W];
      state_ff.cfg.ls_code[0] <=
        {RST_OUT1_UP[UP_W-1:0], RST_OUT1_MID, RST_OUT1_LO};
      state_ff.cfg.ls_code[1] <=
        {RST_OUT2_UP[UP_W-1:0], RST_OUT2_MID, RST_OUT2_LO};
      state_ff.cfg.ls_code[2] <=
        {RST_OUT3_UP[UP_W-1:0], RST_OUT3_MID, RST_OUT3_LO};
      state_ff.irq <= IRQ_PIN_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // outputs straight from flops
  assign rsp_o = state_ff.rsp;
  assign irq_o = state_ff.irq;
  assign flags_o = state_ff.flags;
  assign clock_output_one_o = out_tick[0];
  assign clock_output_two_o = out_tick[1];
  assign clock_output_three_o = out_tick[2];

  // the pin's reset level is fixed, not polarity aware, so checks on
  // registered state start from the first edge after reset release
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_FOS_IRQ: assert property (
    (irq_pin_en_i &&
     |(state_ff.flags[MASK_W-1:MASK_FOS_LSB] &
       ~state_ff.mask[MASK_W-1:MASK_FOS_LSB]))
    |=> state_ff.irq_act)
    else $error("unmasked offset alarm did not raise interrupt");
  AST_LOCK_IRQ: assert property (
    (irq_pin_en_i && state_ff.flags[MASK_LOCK_BIT] &&
     !state_ff.mask[MASK_LOCK_BIT]) |=> state_ff.irq_act)
    else $error("unmasked lock loss did not raise interrupt");
  AST_MASKED_QUIET: assert property (
    !(|(state_ff.flags & ~state_ff.mask)) |=> !state_ff.irq_act)
    else $error("interrupt active with every flag masked");
  AST_MASK_KEEPS_FLAGS: assert property (
    (req_i.wr && req_i.addr == OFF_MASK) |=>
    state_ff.flags == (($past(state_ff.flags) & ~$past(flag_clr_i)) |
                       $past(alarm_q)))
    else $error("mask write disturbed latched flags");
  AST_OUT1_SPLIT: assert property (
    (req_i.wr && req_i.addr == OFF_OUT1_MID) |=>
    state_ff.cfg.ls_code[0][LS_MID_LSB+:DATA_W] == $past(req_i.wdata))
    else $error("output one middle byte not stored");
  AST_OUT2_SPLIT: assert property (
    (req_i.wr && req_i.addr == OFF_OUT2_UP) |=>
    state_ff.cfg.ls_code[1][LS_UP_LSB+:UP_W] ==
      $past(req_i.wdata[UP_W-1:0]))
    else $error("output two upper nibble not stored");
  AST_OUT3_SPLIT: assert property (
    (req_i.wr && req_i.addr == OFF_OUT3_LO) |=>
    state_ff.cfg.ls_code[2][DATA_W-1:0] == $past(req_i.wdata))
    else $error("output three low byte not stored");
  AST_PIN_POLARITY: assert property (
    !sys_rst_i |=> state_ff.irq ==
    ($past(irq_output_polarity_i) ? state_ff.irq_act : !state_ff.irq_act))
    else $error("interrupt pin level ignores polarity");
  // the host leaves one idle cycle between strobes
  AST_HS_READBACK: assert property (
    (req_i.wr && req_i.addr == OFF_OUT1_UP && !req_i.rd) ##1 !req_i.wr ##1
    (req_i.rd && req_i.addr == OFF_OUT1_UP && !req_i.wr) |=>
    rsp_o.data[HS_LSB+:HS_W] == $past(req_i.wdata[HS_LSB+:HS_W], 3))
    else $error("fast divider code read back wrong");

  // register image follows each accepted write on the next edge
  AST_MASK_STORE: assert property (
    (req_i.wr && req_i.addr == OFF_MASK) |=>
    state_ff.mask == $past(req_i.wdata[MASK_W-1:0]))
    else $error("mask write not stored");
  AST_OUT1_UPPER: assert property (
    (req_i.wr && req_i.addr == OFF_OUT1_UP) |=>
    state_ff.cfg.ls_code[0][LS_UP_LSB+:UP_W] ==
      $past(req_i.wdata[UP_W-1:0]))
    else $error("output one upper nibble not stored");
  AST_OUT1_LOW: assert property (
    (req_i.wr && req_i.addr == OFF_OUT1_LO) |=>
    state_ff.cfg.ls_code[0][DATA_W-1:0] == $past(req_i.wdata))
    else $error("output one low byte not stored");
  AST_OUT2_MIDDLE: assert property (
    (req_i.wr && req_i.addr == OFF_OUT2_MID) |=>
    state_ff.cfg.ls_code[1][LS_MID_LSB+:DATA_W] == $past(req_i.wdata))
    else $error("output two middle byte not stored");
  AST_OUT3_UPPER: assert property (
    (req_i.wr && req_i.addr == OFF_OUT3_UP) |=>
    state_ff.cfg.ls_code[2][LS_UP_LSB+:UP_W] ==
      $past(req_i.wdata[UP_W-1:0]))
    else $error("output three upper nibble not stored");

  // reads answer exactly one cycle later, and only then
  AST_READ_ANSWER: assert property (req_i.rd |=> rsp_o.valid)
    else $error("read strobe got no answer");
  AST_NO_STRAY_ANSWER: assert property (!req_i.rd |=> !rsp_o.valid)
    else $error("answer without read strobe");
  AST_RESERVED_ZERO: assert property (
    (req_i.rd && (req_i.addr == OFF_OUT2_UP || req_i.addr == OFF_OUT3_UP))
    |=> rsp_o.data[DATA_W-1:UP_W] == '0)
    else $error("reserved divider bits read as one");

  // a disabled pin never carries an active interrupt
  AST_PIN_DISABLED: assert property (
    !irq_pin_en_i |=> !state_ff.irq_act)
    else $error("interrupt active with pin disabled");
  // a raised alarm is latched on the very next edge, clear or not
  AST_FLAG_SET_WINS: assert property (
    !sys_rst_i |=> (state_ff.flags & $past(alarm_q)) == $past(alarm_q))
    else $error("raised alarm not latched");

  // each alarm bit alone: a masked flag never reaches the pin
  for (genvar g = 0; g < NUM_ALARM; g++) begin : g_alarm_chk
    AST_MASKED_BIT: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      (state_ff.flags == (NUM_ALARM'(1) << g) && state_ff.mask[g])
      |=> !state_ff.irq_act)
      else $error("masked alarm reached the interrupt");
  end

  COV_IRQ_RISE: cover property ($rose(state_ff.irq_act));
  COV_MASK_WRITE: cover property (req_i.wr && req_i.addr == OFF_MASK);
  COV_SET_CLEAR_MEET: cover property (|(alarm_q & flag_clr_i));
  COV_READ: cover property (rsp_o.valid);
endmodule : amd_regs

// ---- test/amd_host_model.sv ----
// host controller model driving the register strobe port of the bank
`timescale 1ns/10ps
module amd_host_model
  import amd_pkg::*;
(
  input wire logic clk_i,
  input wire amd_pkg::amd_rsp_type rsp_i,
  output amd_pkg::amd_req_type req_o
);
  // idle port until the bench asks for a transfer
  initial begin
    req_o = '0;
  end

  // one write strobe, then gap idle cycles to mimic a slow host
  task automatic write(input amd_byte_type a, input amd_byte_type d,
                       input int gap);
    amd_byte_type v;
    v = d;
    // low bytes of slow codes kept zero or odd; a nonzero low byte gets bit zero set
    if (a == OFF_OUT1_LO || a == OFF_OUT2_LO || a == OFF_OUT3_LO) begin
      v = d | {7'h00, |d};
    end
    @(posedge clk_i);
    req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk_i);
    req_o <= '0;
    repeat (gap) @(posedge clk_i);
  endtask : write

  // one read strobe; answer looked for in a bounded window
  task automatic read(input amd_byte_type a, output amd_byte_type d,
                      output bit ok);
    @(posedge clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_i);
    req_o <= '0;
    ok = 1'b0;
    d = 8'h00;
    for (int i = 0; i < 4 && !ok; i++) begin
      #1;
      if (rsp_i.valid === 1'b1) begin
        ok = 1'b1;
        d = rsp_i.data;
      end else begin
        @(posedge clk_i);
      end
    end
  endtask : read
endmodule : amd_host_model

// ---- test/amd_regs_tb_top.sv ----
// self-checking bench for the alarm mask and divider register bank
`timescale 1ns/10ps
module amd_regs_tb_top
  import amd_pkg::*;
;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  amd_req_type req;
  amd_rsp_type rsp;
  logic [4:0] alarm_raw = 5'h00;
  logic [4:0] flag_clr = 5'h00;
  logic irq_pin_en = 1'b0;
  logic irq_pol = 1'b0;
  logic skew_inc = 1'b0;
  logic irq;
  logic [4:0] flags;
  logic [2:0] ticks;
  logic skew_ignored;
  int fails = 0;
  int comparisons = 0;
  int seed = 32'h16C1;
  amd_byte_type mirror [256];
  amd_byte_type offs [12] = '{OFF_MASK, OFF_OUT1_UP, OFF_OUT1_MID,
    OFF_OUT1_LO, OFF_OUT2_UP, OFF_OUT2_MID, OFF_OUT2_LO, OFF_OUT3_UP,
    OFF_OUT3_MID, OFF_OUT3_LO, 8'h22, 8'h05};
  amd_byte_type rsts [10] = '{RST_MASK, RST_OUT1_UP, RST_OUT1_MID,
    RST_OUT1_LO, RST_OUT2_UP, RST_OUT2_MID, RST_OUT2_LO, RST_OUT3_UP,
    RST_OUT3_MID, RST_OUT3_LO};

  // 25 MHz clock
  always #20 clk_i = ~clk_i;

  amd_host_model amd_host_model_inst (.clk_i(clk_i), .rsp_i(rsp),
    .req_o(req));

  amd_regs amd_regs_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .req_i(req), .rsp_o(rsp), .alarm_raw_i(alarm_raw),
    .flag_clr_i(flag_clr), .irq_pin_en_i(irq_pin_en),
    .irq_output_polarity_i(irq_pol), .skew_inc_i(skew_inc), .irq_o(irq),
    .flags_o(flags), .clock_output_one_o(ticks[0]),
    .clock_output_two_o(ticks[1]), .clock_output_three_o(ticks[2]),
    .skew_ignored_o(skew_ignored));

  // readback image: reserved bits zero, unmapped places zero
  function automatic amd_byte_type exp_val(amd_byte_type a,
                                           amd_byte_type d);
    case (a)
      OFF_MASK: return d & 8'h1F;
      OFF_OUT1_UP: return d & 8'hEF;
      OFF_OUT2_UP, OFF_OUT3_UP: return d & 8'h0F;
      OFF_OUT1_LO, OFF_OUT2_LO, OFF_OUT3_LO: return d | {7'h00, |d};
      OFF_OUT1_MID, OFF_OUT2_MID, OFF_OUT3_MID: return d;
      default: return 8'h00;
    endcase
  endfunction : exp_val

  task automatic final_report;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  task automatic check_byte(input string nm, input amd_byte_type e,
                            input amd_byte_type g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : check_byte

  task automatic check_bit(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask : check_bit

  // periods are counted by the bench itself, so plain ints suffice
  task automatic check_num(input string nm, input int e, input int g);
    comparisons++;
    if (g != e) begin
      fails++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask : check_num

  // a limit that runs out is a mismatch and ends the run
  task automatic give_up(input string nm);
    fails++;
    $display("wrong value %s expected answer seen none", nm);
    final_report();
  endtask : give_up

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc

  task automatic wr(input amd_byte_type a, input amd_byte_type d,
                    input int gap);
    amd_host_model_inst.write(a, d, gap);
    mirror[a] = exp_val(a, d);
  endtask : wr

  task automatic rd_chk(input amd_byte_type a);
    amd_byte_type d;
    bit ok;
    amd_host_model_inst.read(a, d, ok);
    if (!ok) give_up("read answer");
    check_byte($sformatf("register %h", a), mirror[a], d);
  endtask : rd_chk

  // align on one tick of output k, then count cycles to the next
  task automatic meas(input int k, input int exp_p);
    int n;
    bit seen;
    n = 0;
    for (int r = 0; r < 2; r++) begin
      seen = 1'b0;
      n = 0;
      for (int i = 0; i < 3000 && !seen; i++) begin
        cyc(1);
        n++;
        seen = (ticks[k] === 1'b1);
      end
      if (!seen) give_up("output tick");
    end
    check_num($sformatf("period of output %0d", k + 1), exp_p, n);
  endtask : meas

  // bounded wait for the latched flags in m
  task automatic wait_flag(input logic [4:0] m);
    for (int i = 0; i < 12; i++) begin
      if ((flags & m) === m) return;
      cyc(1);
    end
    give_up("alarm flag");
  endtask : wait_flag

  initial begin
    logic [2:0] hs;
    amd_byte_type ls [3];
    amd_byte_type ls_tab [4];
    amd_byte_type up_o [3];
    amd_byte_type lo_o [3];
    logic [4:0] one;
    logic pol;
    bit hit;
    int idx;
    ls_tab = '{8'h00, 8'h01, 8'h03, 8'h05};
    up_o = '{OFF_OUT1_UP, OFF_OUT2_UP, OFF_OUT3_UP};
    lo_o = '{OFF_OUT1_LO, OFF_OUT2_LO, OFF_OUT3_LO};
    foreach (mirror[i]) mirror[i] = 8'h00;
    for (int i = 0; i < 10; i++) mirror[offs[i]] = exp_val(offs[i], rsts[i]);
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    // reset values, split divider places, unmapped reads
    for (int i = 0; i < 12; i++) rd_chk(offs[i]);
    // divider ratios: first pass is the plain code-zero case
    for (int t = 0; t < 6; t++) begin
      hs = (t == 0) ? 3'h0 : 3'($random(seed));
      for (int k = 0; k < 3; k++) begin
        idx = (t == 0) ? 0 : ($random(seed) & 3);
        ls[k] = ls_tab[idx];
        wr(up_o[k], (k == 0) ? {hs, 5'h00} : 8'h00, 0);
        wr(up_o[k] + 8'h01, 8'h00, 0);
        wr(lo_o[k], ls[k], 0);
      end
      for (int k = 0; k < 3; k++) begin
        meas(k, (int'(hs) + 4) * (int'(ls[k]) + 1));
      end
    end
    // coarse skew step: refused only at the minimum fast ratio
    for (int c = 0; c < 2; c++) begin
      wr(OFF_OUT1_UP, (c == 0) ? 8'h00 : 8'h40, 0);
      rd_chk(OFF_OUT1_UP);
      @(posedge clk_i);
      skew_inc <= 1'b1;
      hit = 1'b0;
      for (int i = 0; i < 12; i++) begin
        cyc(1);
        hit = hit | (skew_ignored === 1'b1);
      end
      check_bit("skew refused", c == 0, hit);
      @(posedge clk_i);
      skew_inc <= 1'b0;
      cyc(8);
    end
    // each alarm alone: unmasked, refused clear, masked, pin disabled
    for (int b = 0; b < 5; b++) begin
      one = 5'h01 << b;
      pol = b[0];
      @(posedge clk_i);
      irq_pol <= pol;
      irq_pin_en <= 1'b1;
      alarm_raw <= one;
      wr(OFF_MASK, {3'h0, 5'h1F & ~one}, 0);
      wait_flag(one);
      cyc(2);
      check_bit("interrupt pin", pol, irq);
      @(posedge clk_i);
      flag_clr <= one;
      @(posedge clk_i);
      flag_clr <= 5'h00;
      cyc(2);
      check_byte("flags", {3'h0, one}, {3'h0, flags});
      wr(OFF_MASK, 8'h1F, 0);
      cyc(2);
      check_byte("flags", {3'h0, one}, {3'h0, flags});
      check_bit("interrupt pin", ~pol, irq);
      wr(OFF_MASK, {3'h0, 5'h1F & ~one}, 0);
      @(posedge clk_i);
      irq_pin_en <= 1'b0;
      cyc(2);
      check_bit("interrupt pin", ~pol, irq);
      @(posedge clk_i);
      alarm_raw <= 5'h00;
      cyc(8);
      @(posedge clk_i);
      flag_clr <= one;
      @(posedge clk_i);
      flag_clr <= 5'h00;
      cyc(2);
      check_byte("flags", 8'h00, {3'h0, flags});
    end
    // random writes with back-to-back readback, unmapped places included
    for (int i = 0; i < 30; i++) begin
      idx = $random(seed) & 15;
      idx = (idx > 11) ? 11 : idx;
      wr(offs[idx], 8'($random(seed)), $random(seed) & 1);
      rd_chk(offs[idx]);
    end
    final_report();
  end
endmodule : amd_regs_tb_top
